// >>> design/acsce_link_if.sv
// Carrier between the system-clock core and the SPI-clock link logic.
// Assumes the reply word is quiet while a frame runs and snapshots are quiet between frames.
`timescale 1ns/1ps
interface acsce_link_if;
  logic [15:0] reply;
  logic force_hi;
  logic mute;
  logic [15:0] rx;
  logic [4:0] cnt;
  logic hi_start;
  logic hi_end;
  modport link (input reply, input force_hi, input mute,
                output rx, output cnt, output hi_start, output hi_end);
  modport core (output reply, output force_hi, output mute,
                input rx, input cnt, input hi_start, input hi_end);
endinterface

// >>> design/acsce_pkg.sv
// Constants, types and frame helpers of the accelerometer serial command and error logic.
// Assumes a 50 MHz system clock and 16-bit SPI frames from one external master.
package acsce_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int INIT_PH1_US = 100;
  localparam int INIT_BASE_US = 3000;
  localparam int INIT_HPF_US = 200000;
  localparam int INIT_PH1_CYC = INIT_PH1_US * CYC_PER_US;
  localparam int INIT_BASE_CYC = INIT_BASE_US * CYC_PER_US;
  localparam int INIT_HPF_CYC = INIT_HPF_US * CYC_PER_US;
  localparam logic [4:0] FRAME_EDGES = 5'h10;
  localparam int CMD_OP_HI = 15;
  localparam int CMD_AXIS = 14;
  localparam int CMD_ACC = 13;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_TEST = 2'h3;
  localparam logic [4:0] ADDR_CTRL = 5'h0A;
  localparam logic [4:0] ADDR_STAT = 5'h10;
  localparam int CTRL_CE = 0;
  localparam int CTRL_STL = 1;
  localparam int CTRL_STH = 2;
  localparam int CTRL_HPF = 3;
  localparam int STAT_RES = 0;
  localparam int STAT_OFFX = 1;
  localparam int STAT_OFFY = 2;
  localparam int STAT_HPF = 3;
  localparam int STAT_TF = 4;
  localparam int STAT_INIT = 5;
  localparam int STAT_OSC = 6;
  localparam int STAT_IDE = 7;
  localparam logic [1:0] ST_ACC = 2'h1;
  localparam logic [1:0] ST_SELF = 2'h2;
  localparam logic [1:0] ST_ERR = 2'h3;
  localparam logic [9:0] FLG_RESET = 10'h001;
  localparam logic [9:0] FLG_AXIS = 10'h002;
  localparam logic [9:0] FLG_HE = 10'h008;
  localparam logic [9:0] FLG_ND = 10'h010;
  localparam logic [9:0] FLG_CNC = 10'h020;
  localparam logic [9:0] FLG_REQ = 10'h040;
  localparam logic [9:0] FLG_SPI = 10'h080;
  localparam logic AXIS_Y_OK = 1'b1;

  typedef enum logic [2:0] {
    PH_BOOT = 3'b001,
    PH_WARM = 3'b010,
    PH_RUN = 3'b100
  } acsce_phase_t;

  // Builds a status frame; bit 12 makes the count of ones odd.
  function automatic logic [15:0] mk_frame(input logic [2:0] hdr, input logic [1:0] code,
                                           input logic [9:0] body);
    logic [15:0] w;
    w = {hdr, 1'b0, code, body};
    w[12] = ~^w;
    return w;
  endfunction

  localparam logic [15:0] REQ_ERR_FRAME = mk_frame(3'h0, ST_ERR, FLG_REQ);
  localparam logic [15:0] SPI_ERR_FRAME = mk_frame(3'h0, ST_ERR, FLG_SPI);
endpackage

// >>> design/acsce_spi_link.sv
// SPI slave shifter running on the master's serial clock.
// Assumes the serial clock idles low and stands still while chip select is high.
`timescale 1ns/1ps
module acsce_spi_link (
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  acsce_link_if.link lk
);
  logic [15:0] rx_ff;
  logic [4:0] cnt_ff;
  logic tx_ff;
  logic fell_ff;
  logic hi_start_ff;

  // Data is sampled on the rising edge, most significant bit first.
  always_ff @(posedge spi_sclk_i) begin
    rx_ff <= {rx_ff[14:0], spi_mosi_i};
  end

  always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      cnt_ff <= 5'h00;
    end else if (cnt_ff != 5'h1F) begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  // The next reply bit is shifted out on each falling edge.
  always_ff @(negedge spi_sclk_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      fell_ff <= 1'b0;
      tx_ff <= 1'b0;
    end else begin
      fell_ff <= 1'b1;
      tx_ff <= (cnt_ff < acsce_pkg::FRAME_EDGES) ? lk.reply[4'hF - cnt_ff[3:0]] : 1'b0;
    end
  end

  // Clock level at select assertion.
  always_ff @(negedge spi_cs_n_i) begin
    hi_start_ff <= spi_sclk_i;
  end

  // Snapshot at select negation; it stays quiet until the next frame ends.
  always_ff @(posedge spi_cs_n_i) begin
    lk.rx <= rx_ff;
    lk.cnt <= cnt_ff;
    lk.hi_start <= hi_start_ff;
    lk.hi_end <= spi_sclk_i;
  end

  // Bit 15 is presented before the first falling edge; an oscillator fault forces ones except in phase one, where the output is held low.
  assign spi_miso_o = ~lk.mute & (lk.force_hi | (fell_ff ? tx_ff : lk.reply[15]));
endmodule

// >>> design/acsce_sync3.sv
// Three-stage synchroniser with agreement filter.
// Assumes the input may change at any time relative to sys_clk_i.
`timescale 1ns/1ps
module acsce_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } acsce_sync_t;
  acsce_sync_t st;
  acsce_sync_t nxt;

  // A change counts only once the second and third stage agree.
  always_comb begin
    nxt = st;
    nxt.s1 = d_i;
    nxt.s2 = st.s1;
    nxt.s3 = st.s2;
    if (st.s2 == st.s3) begin
      nxt.q = st.s3;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= {RST, RST, RST, RST};
    end else begin
      st <= nxt;
    end
  end

  assign q_o = st.q;
endmodule

// >>> design/acsce_top.sv
// Command decoding, status registers and error reporting of the accelerometer serial port.
// Assumes fault inputs are synchronous to sys_clk_i and frames are at least 200 ns apart.
`timescale 1ns/1ps
module acsce_top #(
  parameter int INIT_PH1_CYC = acsce_pkg::INIT_PH1_CYC,
  parameter int INIT_BASE_CYC = acsce_pkg::INIT_BASE_CYC,
  parameter int INIT_HPF_CYC = acsce_pkg::INIT_HPF_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  input wire logic overtemp_i,
  input wire logic offset_x_i,
  input wire logic offset_y_i,
  input wire logic parity_fault_i,
  input wire logic osc_fault_i,
  input wire logic [9:0] accel_x_i,
  input wire logic [9:0] accel_y_i,
  output logic highpass_select_o,
  output logic selftest_ctrl_hi_o,
  output logic selftest_ctrl_lo_o,
  output logic [7:0] device_status_o
);
  typedef struct packed {
    acsce_pkg::acsce_phase_t phase;
    logic [23:0] timer;
    logic hpf;
    logic st_hi;
    logic st_lo;
    logic reset_seen;
    logic overtemp;
    logic off_y;
    logic off_x;
    logic parity;
    logic osc;
    logic first_pend;
    logic nd_pend;
    logic cs_q;
    logic [15:0] reply;
    logic [7:0] stat;
  } acsce_core_t;

  acsce_core_t st;
  acsce_core_t nxt;

  acsce_link_if lk_if();

  logic cs_sync;
  logic frame_end;
  logic spi_err;
  logic [15:0] cmd;
  logic is_acc;
  logic [1:0] op;
  logic [4:0] addr;
  logic run;
  logic wr_ok;
  logic ce;
  logic nd;
  logic he;
  logic axis;
  logic [9:0] acc_flags;
  logic [23:0] init_lim;

  acsce_sync3 #(
    .W(1),
    .RST(1'b1)
  ) u_cs_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(spi_cs_n_i),
    .q_o(cs_sync)
  );

  acsce_spi_link u_link (
    .spi_sclk_i(spi_sclk_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_mosi_i(spi_mosi_i),
    .spi_miso_o(spi_miso_o),
    .lk(lk_if.link)
  );

  // Control bits readable as one, in their register positions.
  function automatic logic [7:0] ctrl_rb(input logic hpf, input logic sth, input logic stl);
    logic [7:0] v;
    v = 8'h00;
    v[acsce_pkg::CTRL_HPF] = hpf;
    v[acsce_pkg::CTRL_STH] = sth;
    v[acsce_pkg::CTRL_STL] = stl;
    return v;
  endfunction

  function automatic logic [7:0] stat_of(input acsce_core_t c);
    logic [7:0] v;
    v = 8'h00;
    v[acsce_pkg::STAT_IDE] = c.parity;
    v[acsce_pkg::STAT_OSC] = c.osc;
    v[acsce_pkg::STAT_INIT] = (c.phase != acsce_pkg::PH_RUN);
    v[acsce_pkg::STAT_TF] = c.overtemp;
    v[acsce_pkg::STAT_HPF] = c.hpf;
    v[acsce_pkg::STAT_OFFY] = c.off_y;
    v[acsce_pkg::STAT_OFFX] = c.off_x;
    v[acsce_pkg::STAT_RES] = c.reset_seen;
    return v;
  endfunction

  // Picks the error flags of an acceleration request; zero means data may be sent.
  function automatic logic [9:0] pick_flags(input logic bad_conditions_error, input logic par, input logic first,
                                            input logic no_data, input logic hw,
                                            input logic ax);
    logic [9:0] f;
    f = 10'h000;
    if (bad_conditions_error) begin
      f = acsce_pkg::FLG_CNC;
      if (no_data) begin
        f = f | acsce_pkg::FLG_ND;
      end
      if (hw) begin
        f = f | acsce_pkg::FLG_HE;
      end
    end else if (par) begin
      f = acsce_pkg::FLG_HE;
    end else if (first) begin
      f = acsce_pkg::FLG_RESET;
    end else if (no_data) begin
      f = acsce_pkg::FLG_ND;
    end else if (hw) begin
      f = acsce_pkg::FLG_HE;
    end else if (ax && !acsce_pkg::AXIS_Y_OK) begin
      f = acsce_pkg::FLG_AXIS;
    end
    return f;
  endfunction

  assign cmd = lk_if.rx;
  assign is_acc = cmd[acsce_pkg::CMD_ACC];
  assign axis = cmd[acsce_pkg::CMD_AXIS];
  assign op = cmd[15:14];
  assign addr = cmd[12:8];
  assign run = (st.phase == acsce_pkg::PH_RUN);
  // Frames that end during phase one are dropped entirely.
  assign frame_end = cs_sync & ~st.cs_q & (st.phase != acsce_pkg::PH_BOOT);
  assign spi_err = (lk_if.cnt != acsce_pkg::FRAME_EDGES) | lk_if.hi_start | lk_if.hi_end;
  assign wr_ok = frame_end & ~spi_err & ~is_acc & (op == acsce_pkg::OP_WR)
                 & (addr == acsce_pkg::ADDR_CTRL);
  assign ce = wr_ok & cmd[acsce_pkg::CTRL_CE];
  assign nd = ~run | st.nd_pend;
  assign he = st.overtemp | st.off_x | st.off_y | st.parity;
  assign acc_flags = pick_flags(cmd[acsce_pkg::CMD_OP_HI], st.parity, st.first_pend, nd, he, axis);
  assign init_lim = 24'(INIT_BASE_CYC) + (st.hpf ? 24'(INIT_HPF_CYC) : 24'h000000);

  always_comb begin
    nxt = st;
    nxt.cs_q = cs_sync;
    nxt.osc = osc_fault_i;
    nxt.parity = st.parity | parity_fault_i;
    // A condition still present sets its flag again over the clear.
    nxt.overtemp = overtemp_i | (st.overtemp & ~ce);
    nxt.off_x = offset_x_i | (st.off_x & ~ce);
    nxt.off_y = offset_y_i | (st.off_y & ~ce);
    if (ce && run) begin
      nxt.reset_seen = 1'b0;
    end
    if (!run) begin
      nxt.timer = st.timer + 24'h000001;
    end
    unique case (st.phase)
      acsce_pkg::PH_BOOT: begin
        if (st.timer >= 24'(INIT_PH1_CYC)) begin
          nxt.phase = acsce_pkg::PH_WARM;
        end
      end
      acsce_pkg::PH_WARM: begin
        if (st.timer >= init_lim) begin
          nxt.phase = acsce_pkg::PH_RUN;
          nxt.nd_pend = 1'b1;
        end
      end
      acsce_pkg::PH_RUN: begin
      end
    endcase
    // Each frame replaces the reply, so an external error is sent only once.
    if (frame_end) begin
      nxt.first_pend = 1'b0;
      if (spi_err) begin
        nxt.reply = acsce_pkg::SPI_ERR_FRAME;
      end else if (!is_acc) begin
        // Register operations only report oscillator, SPI or request errors.
        unique case (op)
          acsce_pkg::OP_NONE: begin
            nxt.reply = acsce_pkg::REQ_ERR_FRAME;
          end
          acsce_pkg::OP_WR: begin
            if (addr == acsce_pkg::ADDR_CTRL) begin
              nxt.hpf = cmd[acsce_pkg::CTRL_HPF];
              nxt.st_hi = cmd[acsce_pkg::CTRL_STH];
              nxt.st_lo = cmd[acsce_pkg::CTRL_STL];
              nxt.reply = {cmd[15:8], ctrl_rb(nxt.hpf, nxt.st_hi, nxt.st_lo)};
            end else begin
              nxt.reply = acsce_pkg::REQ_ERR_FRAME;
            end
          end
          acsce_pkg::OP_RD: begin
            if (addr == acsce_pkg::ADDR_CTRL) begin
              nxt.reply = {cmd[15:8], ctrl_rb(st.hpf, st.st_hi, st.st_lo)};
            end else if (addr == acsce_pkg::ADDR_STAT) begin
              nxt.reply = {cmd[15:8], st.stat};
            end else begin
              nxt.reply = {cmd[15:8], 8'h00};
            end
          end
          acsce_pkg::OP_TEST: begin
            nxt.reply = {cmd[15:8], st.stat};
          end
        endcase
      end else begin
        if (run && !cmd[acsce_pkg::CMD_OP_HI]) begin
          nxt.nd_pend = 1'b0;
        end
        if (acc_flags != 10'h000) begin
          // Errors always replace acceleration data.
          nxt.reply = acsce_pkg::mk_frame({1'b0, axis, 1'b1}, acsce_pkg::ST_ERR, acc_flags);
        end else if (st.st_hi || st.st_lo) begin
          nxt.reply = acsce_pkg::mk_frame({1'b0, axis, 1'b1}, acsce_pkg::ST_SELF,
                                          axis ? accel_y_i : accel_x_i);
        end else begin
          nxt.reply = acsce_pkg::mk_frame({1'b0, axis, 1'b1}, acsce_pkg::ST_ACC,
                                          axis ? accel_y_i : accel_x_i);
        end
      end
    end
    nxt.stat = stat_of(nxt);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.phase <= acsce_pkg::PH_BOOT;
      st.reset_seen <= 1'b1;
      st.first_pend <= 1'b1;
      st.cs_q <= 1'b1;
      st.reply <= acsce_pkg::REQ_ERR_FRAME;
      st.stat <= 8'h21;
    end else begin
      st <= nxt;
    end
  end

  assign lk_if.reply = st.reply;
  assign lk_if.force_hi = st.osc;
  assign lk_if.mute = (st.phase == acsce_pkg::PH_BOOT);
  assign highpass_select_o = st.hpf;
  assign selftest_ctrl_hi_o = st.st_hi;
  assign selftest_ctrl_lo_o = st.st_lo;
  assign device_status_o = st.stat;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_spi_err;
    frame_end && spi_err |=> st.reply == acsce_pkg::SPI_ERR_FRAME;
  endproperty
  a_spi_err: assert property (p_spi_err)
    else $error("SPI fault not answered with the SPI error frame");

  property p_req_none;
    frame_end && !spi_err && !is_acc && op == acsce_pkg::OP_NONE
      |=> st.reply == acsce_pkg::REQ_ERR_FRAME;
  endproperty
  a_req_none: assert property (p_req_none)
    else $error("Empty operation code not answered with request error");

  property p_bad_wr;
    frame_end && !spi_err && !is_acc && op == acsce_pkg::OP_WR && addr != acsce_pkg::ADDR_CTRL
      |=> $stable({highpass_select_o, selftest_ctrl_hi_o, selftest_ctrl_lo_o})
          && st.reply == acsce_pkg::REQ_ERR_FRAME;
  endproperty
  a_bad_wr: assert property (p_bad_wr)
    else $error("Write to a read-only address changed state or was not refused");

  property p_wr_echo;
    wr_ok |=> st.reply[7:0] == ctrl_rb(highpass_select_o, selftest_ctrl_hi_o,
                                       selftest_ctrl_lo_o);
  endproperty
  a_wr_echo: assert property (p_wr_echo)
    else $error("Write reply does not show the stored control bits");

  property p_test;
    frame_end && !spi_err && !is_acc && op == acsce_pkg::OP_TEST
      |=> st.reply[7:0] == $past(device_status_o);
  endproperty
  a_test: assert property (p_test)
    else $error("Device test reply does not carry the status register");

  property p_boot_quiet;
    st.phase == acsce_pkg::PH_BOOT |=> $stable(st.reply);
  endproperty
  a_boot_quiet: assert property (p_boot_quiet)
    else $error("Reply changed during the first initialization phase");

  property p_res_clear;
    $fell(st.reset_seen) |-> $past(st.phase) == acsce_pkg::PH_RUN && $past(ce);
  endproperty
  a_res_clear: assert property (p_res_clear)
    else $error("Reset-seen flag cleared without a clear-error write after initialization");

  property p_transient;
    overtemp_i |=> device_status_o[acsce_pkg::STAT_TF];
  endproperty
  a_transient: assert property (p_transient)
    else $error("Persisting over-temperature did not keep its flag set");

  property p_offset;
    offset_x_i |=> device_status_o[acsce_pkg::STAT_OFFX];
  endproperty
  a_offset: assert property (p_offset)
    else $error("Persisting offset fault did not keep its flag set");

  property p_nd_init;
    frame_end && !spi_err && is_acc && !cmd[acsce_pkg::CMD_OP_HI] && !st.parity
      && !st.first_pend && !run |=> st.reply[9:0] == acsce_pkg::FLG_ND;
  endproperty
  a_nd_init: assert property (p_nd_init)
    else $error("Acceleration request during initialization not answered with no-data");

  property p_parity_he;
    frame_end && !spi_err && is_acc && !cmd[acsce_pkg::CMD_OP_HI] && st.parity
      |=> st.reply[11:10] == acsce_pkg::ST_ERR && st.reply[9:0] == acsce_pkg::FLG_HE;
  endproperty
  a_parity_he: assert property (p_parity_he)
    else $error("Parity fault not reported as the only hardware error");

  property p_osc;
    osc_fault_i ##1 osc_fault_i |-> lk_if.force_hi;
  endproperty
  a_osc: assert property (p_osc)
    else $error("Oscillator fault did not force the serial output high");

  property p_init_len;
    $rose(run) |-> $past(st.timer) >= 24'(INIT_BASE_CYC);
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("Initialization ended before its base time");

  c_acc_data: cover property (frame_end && is_acc && !spi_err
                              ##1 st.reply[11:10] == acsce_pkg::ST_ACC);
  c_ctrl_wr: cover property (wr_ok);
  c_spi_err: cover property (frame_end && spi_err);
  c_nd_after_init: cover property (frame_end && is_acc && run && st.nd_pend);
endmodule

// >>> tb/acsce_spi_master.sv
// Behavioural SPI master that stands at the far side of the serial port.
// Assumes the device needs at least 200 ns of chip-select high between frames.
`timescale 1ns/1ps
module acsce_spi_master (
  output logic spi_sclk_o,
  output logic spi_cs_n_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i
);
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  // Sends one command and returns what came back; fewer edges make a broken frame.
  task automatic xfer(input logic [15:0] cmd, input int edges, output logic [15:0] rsp);
    rsp = 16'h0000;
    spi_cs_n_o = 1'b0;
    for (int k = 0; k < edges; k++) begin
      spi_mosi_o = cmd[15-k];
      #40;
      rsp[15-k] = spi_miso_i;
      spi_sclk_o = 1'b1;
      #40;
      spi_sclk_o = 1'b0;
    end
    #40;
    spi_cs_n_o = 1'b1;
    // The released data line must not keep its last value.
    spi_mosi_o = ~spi_mosi_o;
    #400;
  endtask
endmodule

// >>> tb/tb_accel_spi_command_error_logic.sv
// Self-checking bench for the serial command and error logic.
// Assumes shortened initialization counts and the master model above.
`timescale 1ns/1ps
module tb_accel_spi_command_error_logic;
  logic sys_clk_i, rst_n_i, sclk, cs_n, mosi, miso;
  logic ot, ox, oy, px, osc, hp, sh, sl;
  logic [7:0] stat;
  logic [15:0] rsp;
  int bad_count, num_checks, cyc;
  // The base time outlasts the first nine frames, so they all fall in phase two.
  acsce_top #(.INIT_PH1_CYC(20), .INIT_BASE_CYC(1200), .INIT_HPF_CYC(400)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .overtemp_i(ot), .offset_x_i(ox),
    .offset_y_i(oy), .parity_fault_i(px), .osc_fault_i(osc),
    .accel_x_i(10'h155), .accel_y_i(10'h2AA), .highpass_select_o(hp),
    .selftest_ctrl_hi_o(sh), .selftest_ctrl_lo_o(sl), .device_status_o(stat));
  acsce_spi_master m_u (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
    .spi_miso_i(miso));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [15:0] fr(input logic [2:0] h, input logic [1:0] c,
                                     input logic [9:0] b);
    logic [15:0] w;
    w = {h, 1'b0, c, b};
    w[12] = ~^w;
    return w;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Sends a command and compares the reply, which belongs to the previous frame.
  task automatic xf(input logic [15:0] cmd, input logic [15:0] exp, input int n = 16);
    m_u.xfer(cmd, n, rsp);
    if (!$isunknown(exp)) chk(rsp, exp);
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      give_verdict();
    end
  end
  localparam logic [15:0] RQ = fr(3'h0, acsce_pkg::ST_ERR, acsce_pkg::FLG_REQ);
  initial begin
    rst_n_i = 1'b0;
    ot = 1'b0;
    ox = 1'b0;
    oy = 1'b0;
    px = 1'b0;
    osc = 1'b0;
    repeat (16) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (30) @(negedge sys_clk_i);
    xf(16'h2000, RQ);
    xf(16'hC000, fr(3'h1, 2'h3, acsce_pkg::FLG_RESET));
    xf(16'h4A01, 16'hC021);
    xf(16'h9000, 16'h4A00);
    xf(16'h5155, 16'h9021);
    xf(16'h0000, RQ);
    xf(16'hA000, RQ, 15);
    xf(16'hA000, fr(3'h0, 2'h3, acsce_pkg::FLG_SPI));
    xf(16'h2000, fr(3'h1, 2'h3, acsce_pkg::FLG_CNC | acsce_pkg::FLG_ND));
    repeat (700) @(negedge sys_clk_i);
    xf(16'h2000, fr(3'h1, 2'h3, acsce_pkg::FLG_ND));
    xf(16'h6000, fr(3'h1, 2'h3, acsce_pkg::FLG_ND));
    xf(16'h4A0E, fr(3'h3, 2'h1, 10'h2AA));
    xf(16'h2000, 16'h4A0E);
    chk({13'h0000, hp, sh, sl}, 16'h0007);
    ot = 1'b1;
    xf(16'h4A01, fr(3'h1, 2'h2, 10'h155));
    xf(16'hC000, 16'h4A00);
    chk({8'h00, stat}, 16'h0010);
    ot = 1'b0;
    ox = 1'b1;
    oy = 1'b1;
    xf(16'h2000, 16'hC010);
    xf(16'h4A01, fr(3'h1, 2'h3, acsce_pkg::FLG_HE));
    xf(16'hC000, 16'h4A00);
    chk({8'h00, stat}, 16'h0006);
    ox = 1'b0;
    oy = 1'b0;
    osc = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    xf(16'hC000, 16'hFFFF);
    osc = 1'b0;
    px = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    xf(16'h2000, 16'hC046);
    xf(16'h2000, fr(3'h1, 2'h3, acsce_pkg::FLG_HE));
    give_verdict();
  end
endmodule
